// file: verilog/dma_channel_control.sv
/*
 * Control and status of four DMA channels behind an APB slave:
 * per-channel control registers, bit-access port, event status and mask.
 * Assumes the bus-cycle engine supplies lastXfer and xferDone pulses and
 * acts on chanEnable, softRequest and forceAbort; inputs are synchronous.
 */
`timescale 1ns/1ps
`include "dma_chan_defs.svh"

module dma_channel_control #(
   parameter int CHANNELS = 4
) (
   input  wire logic                clk,
   input  wire logic                reset_n,
   input  wire logic                ce,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [31:0]         paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [3:0]          pstrb,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                dmaHaltInput,
   input  wire logic [CHANNELS-1:0] lastXfer,
   input  wire logic [CHANNELS-1:0] xferDone,
   output logic      [CHANNELS-1:0] chanEnable,
   output logic      [CHANNELS-1:0] softRequest,
   output logic      [CHANNELS-1:0] forceAbort,
   output logic      [CHANNELS-1:0] terminalCountOut,
   output logic                     irq
);

   // ********************************************************************
   // parameter check
   // ********************************************************************
   generate
      if (CHANNELS < 1 || CHANNELS > 4) begin : gBadChannels
         $error("CHANNELS must lie between 1 and 4");
      end
   endgenerate

   // ********************************************************************
   // address decode
   // ********************************************************************
   localparam logic [31:0] CHAN_INDEX [4] = '{`DCC_CH0_INDEX, `DCC_CH1_INDEX,
                                              `DCC_CH2_INDEX, `DCC_CH3_INDEX};

   // index to byte address; the top bits fall off a 32-bit bus
   function automatic logic [31:0] byteAddr(input logic [31:0] index);
      return {index[29:0], 2'b00};
   endfunction

   function automatic logic [CHANNELS-1:0] chanHit(input logic [31:0] addr);
      logic [CHANNELS-1:0] hit;
      hit = '0;
      for (int i = 0; i < CHANNELS; i++) begin
         hit[i] = (addr == byteAddr(CHAN_INDEX[i]));
      end
      return hit;
   endfunction

   function automatic logic [7:0] ctrlView(input logic done, input logic keep, input logic en);
      logic [7:0] v;
      v = `DCC_CTRL_RESET;
      v[`DCC_DONE_BIT] = done;
      v[`DCC_KEEP_BIT] = keep;
      v[`DCC_EN_BIT]   = en;
      return v;
   endfunction

   logic [CHANNELS-1:0] hitNow;
   logic                hitBitop;
   logic                hitStatus;
   logic                hitMask;
   logic                mapped;
   logic                access;
   logic                writeTake;

   assign hitNow    = chanHit(paddr);
   assign hitBitop  = (paddr == `DCC_BITOP_ADDR);
   assign hitStatus = (paddr == `DCC_STATUS_ADDR);
   assign hitMask   = (paddr == `DCC_MASK_ADDR);
   assign mapped    = (|hitNow) | hitBitop | hitStatus | hitMask;
   assign access    = psel & penable;
   // writes land on the edge that completes the transfer
   assign writeTake = access & pready & pwrite;

   // ********************************************************************
   // channel units
   // ********************************************************************
   dma_chan_pkg::chanWrite_s [CHANNELS-1:0] chanWr;
   logic [CHANNELS-1:0] keepBit;
   logic [CHANNELS-1:0] doneFlag;
   logic [CHANNELS-1:0] rdClear;
   logic [2:0]          bitopBit;
   logic [1:0]          bitopChan;
   logic                readCapture;

   assign bitopBit    = pwdata[`DCC_BITOP_BIT_LSB +: 3];
   assign bitopChan   = pwdata[`DCC_BITOP_CH_LSB +: 2];
   assign readCapture = access & ~pready & ~pwrite;

   always_comb begin
      for (int i = 0; i < CHANNELS; i++) begin
         chanWr[i].mask = 8'h00;
         chanWr[i].data = pwdata[7:0];
         if (writeTake && hitNow[i] && pstrb[0]) begin
            chanWr[i].mask = `DCC_FULL_MASK;
         end
         // single-bit write through the bit-access word
         if (writeTake && hitBitop && pstrb[1] && bitopChan == 2'(i)) begin
            chanWr[i].mask = 8'(1) << bitopBit;
            chanWr[i].data = {8{pwdata[`DCC_BITOP_VAL_BIT]}};
         end
         // the flag is never written by software
         chanWr[i].mask[`DCC_DONE_BIT] = 1'b0;
         rdClear[i] = readCapture & hitNow[i];
      end
   end

   generate
      for (genvar g = 0; g < CHANNELS; g++) begin : gChan
         chan_ctrl_unit uUnit (
            .clk              (clk),
            .reset_n          (reset_n),
            .ce               (ce),
            .wr               (chanWr[g]),
            .rdClear          (rdClear[g]),
            .halt             (dmaHaltInput),
            .evt              ({lastXfer[g], xferDone[g]}),
            .chanEnableBit    (chanEnable[g]),
            .keepEnabledBit   (keepBit[g]),
            .xferDoneFlag     (doneFlag[g]),
            .softRequest      (softRequest[g]),
            .forceAbort       (forceAbort[g]),
            .terminalCountOut (terminalCountOut[g])
         );
      end
   endgenerate

   // ********************************************************************
   // events and interrupt
   // ********************************************************************
   logic [`DCC_EVT_WIDTH-1:0] events;
   logic [`DCC_EVT_WIDTH-1:0] status;
   logic [`DCC_EVT_WIDTH-1:0] mask;
   logic                      haltSeen;
   logic                      next_haltSeen;

   always_comb begin
      events = `DCC_EVT_RESET;
      events[CHANNELS-1:0] = xferDone;
      events[`DCC_EVT_HALT_BIT] = dmaHaltInput & ~haltSeen;
      next_haltSeen = dmaHaltInput;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         haltSeen <= 1'b0;
      end else if (ce) begin
         haltSeen <= next_haltSeen;
      end
   end

   event_status #(
      .WIDTH (`DCC_EVT_WIDTH)
   ) uEvents (
      .clk        (clk),
      .reset_n    (reset_n),
      .ce         (ce),
      .events     (events),
      .statusRead (readCapture & hitStatus),
      .maskWrite  (writeTake & hitMask & pstrb[0]),
      .maskData   (pwdata[`DCC_EVT_WIDTH-1:0]),
      .status     (status),
      .mask       (mask),
      .irq        (irq)
   );

   // ********************************************************************
   // apb answer
   // ********************************************************************
   dma_chan_pkg::apbPhase_e phase;
   dma_chan_pkg::apbPhase_e next_phase;
   logic [31:0]             next_prdata;
   logic                    next_pready;
   logic                    next_pslverr;
   logic                    chanRead;
   logic                    next_chanRead;

   always_comb begin
      next_phase    = phase;
      next_prdata   = prdata;
      next_pready   = 1'b0;
      next_pslverr  = 1'b0;
      next_chanRead = 1'b0;
      case (phase)
         dma_chan_pkg::APB_IDLE: begin
            if (access) begin
               next_phase    = dma_chan_pkg::APB_ANSWER;
               next_pready   = 1'b1;
               next_pslverr  = ~mapped;
               next_prdata   = '0;
               next_chanRead = ~pwrite & (|hitNow);
               if (!pwrite) begin
                  for (int i = 0; i < CHANNELS; i++) begin
                     if (hitNow[i]) begin
                        next_prdata[7:0] = ctrlView(doneFlag[i], keepBit[i], chanEnable[i]);
                     end
                  end
                  if (hitStatus) begin
                     next_prdata[`DCC_EVT_WIDTH-1:0] = status;
                  end
                  if (hitMask) begin
                     next_prdata[`DCC_EVT_WIDTH-1:0] = mask;
                  end
               end
            end
         end
         dma_chan_pkg::APB_ANSWER: begin
            next_phase = dma_chan_pkg::APB_IDLE;
         end
         default: begin
            next_phase = dma_chan_pkg::APB_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase    <= dma_chan_pkg::APB_IDLE;
         prdata   <= '0;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
         chanRead <= 1'b0;
      end else if (ce) begin
         phase    <= next_phase;
         prdata   <= next_prdata;
         pready   <= next_pready;
         pslverr  <= next_pslverr;
         chanRead <= next_chanRead;
      end
   end

   // ********************************************************************
   // assertions
   // ********************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence apbSetup;
      psel && !penable;
   endsequence

   sequence apbWaitAnswer;
      access && !pready && ce ##1 pready;
   endsequence

   apb_answer_time_a : assert property (apbSetup ##1 apbWaitAnswer |-> phase == dma_chan_pkg::APB_ANSWER)
      else $error("apb answer not one cycle after access");
   apb_pready_pulse_a : assert property (pready && ce |=> !pready)
      else $error("pready held beyond one cycle");
   wo_bits_zero_a : assert property (pready && chanRead |-> prdata[2:1] == 2'b00 && prdata[6:4] == 3'b000)
      else $error("write-only bits read nonzero");
   halt_clears_all_a : assert property (ce && dmaHaltInput |=> chanEnable == '0)
      else $error("halt left a channel enabled");
   irq_follows_status_a : assert property (ce |=> irq == |(status & mask))
      else $error("interrupt disagrees with status and mask");

   generate
      for (genvar g = 0; g < CHANNELS; g++) begin : gChk
         flag_set_a : assert property (ce && lastXfer[g] |=> doneFlag[g])
            else $error("completion flag not set on final transfer");
         flag_write_a : assert property (ce && !lastXfer[g] && !doneFlag[g] && chanWr[g].mask != 8'h00
                                          |=> !doneFlag[g])
            else $error("software write reached the completion flag");
         tc_pulse_a : assert property (ce && xferDone[g] |=> terminalCountOut[g])
            else $error("terminal count pulse missing");
         done_disable_a : assert property (ce && xferDone[g] && !keepBit[g] |=> !chanEnable[g])
            else $error("channel still enabled after completion");
         keep_enabled_a : assert property (ce && xferDone[g] && keepBit[g] && chanEnable[g] && !dmaHaltInput
                                            && chanWr[g].mask == 8'h00 |=> chanEnable[g])
            else $error("keep-enabled channel was disabled");
         force_term_a : assert property (ce && chanWr[g].mask[`DCC_FORCE_BIT] && chanWr[g].data[`DCC_FORCE_BIT]
                                          |=> !chanEnable[g] && forceAbort[g])
            else $error("forced termination not applied");
         trig_gate_a : assert property (ce && softRequest[g] |-> $past(chanEnable[g]) &&
                                         (!$past(doneFlag[g]) || $past(keepBit[g])))
            else $error("request raised while channel not ready");
         enable_gate_a : assert property (ce && !chanEnable[g] |=> !softRequest[g])
            else $error("request issued on a disabled channel");
      end
   endgenerate

endmodule // dma_channel_control

// file: verilog/dma_chan_defs.svh
/*
 * Register map, field positions and reset values of the DMA channel
 * control block. Holds definitions only; included by bare name.
 */
`ifndef DMA_CHAN_DEFS_SVH
`define DMA_CHAN_DEFS_SVH

// ********************************************************************
// register indices (byte address is four times the index)
// ********************************************************************
`define DCC_CH0_INDEX      32'hfffff0e0
`define DCC_CH1_INDEX      32'hfffff0e2
`define DCC_CH2_INDEX      32'hfffff0e4
`define DCC_CH3_INDEX      32'h0ffff0e6

// ********************************************************************
// block-local registers (byte addresses)
// ********************************************************************
`define DCC_BITOP_ADDR     32'h00000010
`define DCC_STATUS_ADDR    32'h00000014
`define DCC_MASK_ADDR      32'h00000018

// ********************************************************************
// channel control register fields
// ********************************************************************
`define DCC_EN_BIT         0
`define DCC_TRIG_BIT       1
`define DCC_FORCE_BIT      2
`define DCC_KEEP_BIT       3
`define DCC_DONE_BIT       7
`define DCC_CTRL_RESET     8'h00
`define DCC_FULL_MASK      8'hff

// ********************************************************************
// bit-access word: channel, bit number, value
// ********************************************************************
`define DCC_BITOP_CH_LSB   0
`define DCC_BITOP_BIT_LSB  2
`define DCC_BITOP_VAL_BIT  8

// ********************************************************************
// event status layout
// ********************************************************************
`define DCC_EVT_HALT_BIT   4
`define DCC_EVT_WIDTH      5
`define DCC_EVT_RESET      5'h00

`endif

// file: verilog/dma_chan_pkg.sv
/*
 * Types shared by the DMA channel control block.
 * Assumes the defines header is compiled alongside.
 */
package dma_chan_pkg;

   // one write into a channel control register, byte or single bit
   typedef struct packed {
      logic [7:0] mask;
      logic [7:0] data;
   } chanWrite_s;

   // events from the bus-cycle engine for one channel
   typedef struct packed {
      logic lastXfer;
      logic xferDone;
   } chanEvent_s;

   typedef enum logic {
      APB_IDLE,
      APB_ANSWER
   } apbPhase_e;

endpackage

// file: verilog/chan_ctrl_unit.sv
/*
 * One channel's control register: enable, keep-enabled, completion
 * flag, forced termination and software trigger.
 * Assumes writes and read-clears arrive as single-cycle strobes.
 */
`timescale 1ns/1ps
`include "dma_chan_defs.svh"

module chan_ctrl_unit (
   input  wire logic                     clk,
   input  wire logic                     reset_n,
   input  wire logic                     ce,
   input  wire dma_chan_pkg::chanWrite_s wr,
   input  wire logic                     rdClear,
   input  wire logic                     halt,
   input  wire dma_chan_pkg::chanEvent_s evt,
   output logic                          chanEnableBit,
   output logic                          keepEnabledBit,
   output logic                          xferDoneFlag,
   output logic                          softRequest,
   output logic                          forceAbort,
   output logic                          terminalCountOut
);

   logic next_chanEnableBit;
   logic next_keepEnabledBit;
   logic next_xferDoneFlag;
   logic next_softRequest;
   logic next_forceAbort;
   logic next_terminalCountOut;
   logic forceHit;
   logic trigHit;

   always_comb begin
      forceHit = wr.mask[`DCC_FORCE_BIT] & wr.data[`DCC_FORCE_BIT];
      trigHit  = wr.mask[`DCC_TRIG_BIT] & wr.data[`DCC_TRIG_BIT];
      next_keepEnabledBit = wr.mask[`DCC_KEEP_BIT] ? wr.data[`DCC_KEEP_BIT] : keepEnabledBit;
      next_chanEnableBit  = wr.mask[`DCC_EN_BIT] ? wr.data[`DCC_EN_BIT] : chanEnableBit;
      if (evt.xferDone && !keepEnabledBit) begin
         next_chanEnableBit = 1'b0;
      end
      // halt and forced stop win over software
      if (halt || forceHit) begin
         next_chanEnableBit = 1'b0;
      end
      next_xferDoneFlag = (xferDoneFlag & ~rdClear) | evt.lastXfer;
      // trigger needs enable, and either a clear flag or the keep bit set
      next_softRequest = trigHit & chanEnableBit & (~xferDoneFlag | keepEnabledBit);
      next_forceAbort = forceHit;
      next_terminalCountOut = evt.xferDone;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         chanEnableBit    <= 1'b0;
         keepEnabledBit   <= 1'b0;
         xferDoneFlag     <= 1'b0;
         softRequest      <= 1'b0;
         forceAbort       <= 1'b0;
         terminalCountOut <= 1'b0;
      end else if (ce) begin
         chanEnableBit    <= next_chanEnableBit;
         keepEnabledBit   <= next_keepEnabledBit;
         xferDoneFlag     <= next_xferDoneFlag;
         softRequest      <= next_softRequest;
         forceAbort       <= next_forceAbort;
         terminalCountOut <= next_terminalCountOut;
      end
   end

endmodule // chan_ctrl_unit

// file: verilog/event_status.sv
/*
 * Sticky event status with mask and one level interrupt.
 * Assumes statusRead is a single-cycle strobe at the read's data capture.
 */
`timescale 1ns/1ps
`include "dma_chan_defs.svh"

module event_status #(
   parameter int WIDTH = `DCC_EVT_WIDTH
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] events,
   input  wire logic             statusRead,
   input  wire logic             maskWrite,
   input  wire logic [WIDTH-1:0] maskData,
   output logic      [WIDTH-1:0] status,
   output logic      [WIDTH-1:0] mask,
   output logic                  irq
);

   logic [WIDTH-1:0] next_status;
   logic [WIDTH-1:0] next_mask;
   logic             next_irq;

   always_comb begin
      // an event in the clearing cycle survives
      next_status = (statusRead ? '0 : status) | events;
      next_mask   = maskWrite ? maskData : mask;
      next_irq    = |(next_status & next_mask);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status <= '0;
         mask   <= '0;
         irq    <= 1'b0;
      end else if (ce) begin
         status <= next_status;
         mask   <= next_mask;
         irq    <= next_irq;
      end
   end

endmodule // event_status

// file: tb/tb_dma_channel_control.sv
/*
 * Self-checking bench for the four-channel DMA control block.
 * Assumes the block answers APB one cycle into the access phase; ce is driven here.
 */
`timescale 1ns/1ps
`include "dma_chan_defs.svh"

module tb_dma_channel_control;
   localparam logic [31:0] CH0    = `DCC_CH0_INDEX << 2;
   localparam logic [31:0] CH1    = `DCC_CH1_INDEX << 2;
   localparam logic [31:0] CH2    = `DCC_CH2_INDEX << 2;
   localparam logic [31:0] CH3    = `DCC_CH3_INDEX << 2;
   localparam logic [31:0] BITOP  = `DCC_BITOP_ADDR;
   localparam logic [31:0] STATUS = `DCC_STATUS_ADDR;
   localparam logic [31:0] MASK   = `DCC_MASK_ADDR;

   typedef struct {
      logic [31:0] wa, wd;
      logic [3:0]  st;
      logic [31:0] ra, rd;
      logic        er;
   } row_s;

   logic        clk, reset_n, ce, psel, penable, pwrite, pready, pslverr, dmaHaltInput, irq;
   logic [31:0] paddr, pwdata, prdata;
   logic [3:0]  pstrb, lastXfer, xferDone, chanEnable, softRequest, forceAbort, terminalCountOut;
   int          badCount, checkCount;
   logic [31:0] rdv;
   logic        erv;

   // ********************************************************************
   // ordinary cases: write, then read back
   // ********************************************************************
   row_s rows[8] = '{
      '{CH0, 32'h00000089, 4'h1, CH0, 32'h00000009, 1'b0},
      '{CH1, 32'h00000001, 4'h1, CH1, 32'h00000001, 1'b0},
      '{CH2, 32'h00000008, 4'h1, CH2, 32'h00000008, 1'b0},
      '{CH3, 32'h000000ff, 4'h1, CH3, 32'h00000008, 1'b0},
      '{CH1, 32'h00000000, 4'he, CH1, 32'h00000001, 1'b0},
      '{BITOP, 32'h00000102, 4'h2, CH2, 32'h00000009, 1'b0},
      '{MASK, 32'h0000001f, 4'h1, MASK, 32'h0000001f, 1'b0},
      '{32'h00000020, 32'h0000005a, 4'h1, 32'h00000020, 32'h00000000, 1'b1}
   };

   dma_channel_control dut_u (
      .clk              (clk),
      .reset_n          (reset_n),
      .ce               (ce),
      .psel             (psel),
      .penable          (penable),
      .pwrite           (pwrite),
      .paddr            (paddr),
      .pwdata           (pwdata),
      .pstrb            (pstrb),
      .prdata           (prdata),
      .pready           (pready),
      .pslverr          (pslverr),
      .dmaHaltInput     (dmaHaltInput),
      .lastXfer         (lastXfer),
      .xferDone         (xferDone),
      .chanEnable       (chanEnable),
      .softRequest      (softRequest),
      .forceAbort       (forceAbort),
      .terminalCountOut (terminalCountOut),
      .irq              (irq)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ********************************************************************
   // compare, bus and closing tasks
   // ********************************************************************
   task automatic checkWord(input logic [31:0] g, input logic [31:0] e);
      checkCount++;
      if (g !== e) begin
         badCount++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic checkBits(input logic [3:0] g, input logic [3:0] e);
      checkCount++;
      if (g !== e) begin
         badCount++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // request held from setup until pready is sampled high
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic er);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, 4'h1, r, e);
   endtask

   task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h00000000, 4'h0, r, e);
      checkWord(r, exp);
   endtask

   // irq is registered on the same edge as status; let it settle first
   task automatic irqLater(input logic exp);
      repeat (3) @(posedge clk);
      #1;
      checkBits({3'h0, irq}, {3'h0, exp});
   endtask

   task automatic completeRun();
      if (badCount == 0 && checkCount > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      #40000;
      badCount++;
      completeRun();
   end

   // ********************************************************************
   // main sequence
   // ********************************************************************
   initial begin
      reset_n = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h00000000;
      pwdata = 32'h00000000;
      pstrb = 4'h0;
      dmaHaltInput = 1'b0;
      lastXfer = 4'h0;
      xferDone = 4'h0;
      badCount = 0;
      checkCount = 0;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      foreach (rows[i]) begin
         apb(1'b1, rows[i].wa, rows[i].wd, rows[i].st, rdv, erv);
         checkBits({3'h0, erv}, {3'h0, rows[i].er});
         apb(1'b0, rows[i].ra, 32'h00000000, 4'h0, rdv, erv);
         checkWord(rdv, rows[i].rd);
      end
      checkBits(chanEnable, 4'h7);
      // trigger taken only when enabled
      wr(CH0, 32'h0000000b);
      #1 checkBits(softRequest, 4'h1);
      wr(CH3, 32'h0000000a);
      #1 checkBits(softRequest, 4'h0);
      wr(CH0, 32'h0000000d);
      #1 checkBits(forceAbort, 4'h1);
      checkBits(chanEnable, 4'h6);
      // final transfer then completion on channels 1 and 2
      @(posedge clk) lastXfer <= 4'h6;
      @(posedge clk) lastXfer <= 4'h0;
      xferDone <= 4'h6;
      @(posedge clk) xferDone <= 4'h0;
      #1 checkBits(terminalCountOut, 4'h6);
      checkBits(chanEnable, 4'h4);
      irqLater(1'b1);
      wr(CH2, 32'h0000000b);
      #1 checkBits(softRequest, 4'h4);
      wr(CH1, 32'h00000001);
      wr(CH1, 32'h00000003);
      #1 checkBits(softRequest, 4'h0);
      rdc(CH1, 32'h00000081);
      rdc(CH1, 32'h00000001);
      wr(CH1, 32'h00000003);
      #1 checkBits(softRequest, 4'h2);
      rdc(CH2, 32'h00000089);
      rdc(STATUS, 32'h00000006);
      irqLater(1'b0);
      // halt clears every enable; event masked, then unmasked
      wr(MASK, 32'h00000000);
      @(posedge clk) dmaHaltInput <= 1'b1;
      @(posedge clk) dmaHaltInput <= 1'b0;
      #1 checkBits(chanEnable, 4'h0);
      irqLater(1'b0);
      wr(MASK, 32'h00000010);
      irqLater(1'b1);
      rdc(STATUS, 32'h00000010);
      irqLater(1'b0);
      // reset in mid-run returns every register to its reset value
      wr(CH0, 32'h00000009);
      @(posedge clk) reset_n <= 1'b0;
      #1 checkBits(chanEnable, 4'h0);
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      rdc(CH0, 32'h00000000);
      rdc(CH1, 32'h00000000);
      rdc(CH2, 32'h00000000);
      rdc(CH3, 32'h00000000);
      rdc(MASK, 32'h00000000);
      // frozen clock enable must ignore a completion
      wr(CH0, 32'h00000001);
      ce       <= 1'b0;
      xferDone <= 4'h1;
      @(posedge clk) ce <= 1'b1;
      xferDone <= 4'h0;
      #1 checkBits(chanEnable, 4'h1);
      checkBits(terminalCountOut, 4'h0);
      completeRun();
   end
endmodule // tb_dma_channel_control
